// ===== verilog/apgu_defs.svh
`ifndef APGU_DEFS_SVH
`define APGU_DEFS_SVH

// Register byte addresses on the register bus
`define APGU_ADDR_W          20
`define APGU_CTRL_ADDR       20'hf0078
`define APGU_CAUSE_ADDR      20'hf007c
`define APGU_STS_ADDR        20'hf0080
`define APGU_MASK_ADDR       20'hf0084

// Protection control layout and reset
`define APGU_CTRL_RST        8'h00
`define APGU_CTRL_WMASK      8'hb7
`define APGU_DET_EN_BIT      7

// Reset cause register layout
`define APGU_CAUSE_FLAG_BIT  0

// Event status / mask layout
`define APGU_EVT_W           2
`define APGU_EVT_VIOL_RST    0
`define APGU_EVT_VIOL_QUIET  1
`define APGU_EVT_RST         2'h0

// Guarded RAM window
`define APGU_RAM_BASE        20'hfef00
`define APGU_RAM_SZ_OFF      10'h000
`define APGU_RAM_SZ_128      10'h080
`define APGU_RAM_SZ_256      10'h100
`define APGU_RAM_SZ_512      10'h200
`define APGU_RAM_SEL_OFF     2'h0
`define APGU_RAM_SEL_128     2'h1
`define APGU_RAM_SEL_256     2'h2

// Bus responses
`define APGU_RESP_OKAY       2'h0
`define APGU_RESP_SLVERR     2'h2

`endif

// ===== verilog/apgu_pkg.sv
package apgu_pkg;

    // Kind of target a CPU write goes to, from the outer decoder
    typedef enum logic [2:0] {
        CLS_OTHER,
        CLS_RAM,
        CLS_PORT_CFG,
        CLS_PORT_DATA,
        CLS_IRQ_CFG,
        CLS_CHIP_CTL
    } apgu_cls_t;

    // Protection control register, bit 7 down to bit 0
    typedef struct packed {
        logic       det_en;        // Violation detect enable
        logic       rsv6;          // Reads zero
        logic [1:0] ram_size;      // Ram guard size hi/lo
        logic       rsv3;          // Reads zero
        logic       port_guard;    // Port config guard
        logic       irq_guard;     // Irq config guard
        logic       chip_guard;    // Chip control guard
    } apgu_ctrl_t;

    // One CPU write beat
    typedef struct packed {
        logic        valid;        // Write strobe
        logic [19:0] addr;         // Byte address
        logic [7:0]  data;         // Write data
        apgu_cls_t   cls;          // Target kind
    } apgu_wr_t;

    // Read channel state
    typedef enum {
        RD_IDLE,
        RD_RESP
    } apgu_rd_st_t;

endpackage : apgu_pkg

// ===== verilog/apgu_wr_guard.sv
`timescale 1ns/100ps
`include "apgu_defs.svh"

module apgu_wr_guard (
    input  wire apgu_pkg::apgu_ctrl_t ctrl,  // Current protection control
    input  wire apgu_pkg::apgu_wr_t   wr,    // CPU write beat
    output logic                      block  // High when write is dropped
);

    logic [9:0]  ram_lim;  // Guarded bytes from ram base
    logic [19:0] ram_off;  // Offset of write into ram

    // Decode guarded window size
    always_comb begin
        case (ctrl.ram_size)
            `APGU_RAM_SEL_OFF: ram_lim = `APGU_RAM_SZ_OFF;
            `APGU_RAM_SEL_128: ram_lim = `APGU_RAM_SZ_128;
            `APGU_RAM_SEL_256: ram_lim = `APGU_RAM_SZ_256;
            default:           ram_lim = `APGU_RAM_SZ_512;
        endcase
    end

    // Offset wraps when below base, so the compare below rejects it
    assign ram_off = wr.addr - `APGU_RAM_BASE;

    // Pick the guard that covers the target; data ports never blocked
    always_comb begin
        block = 1'b0;
        if (wr.valid) begin
            case (wr.cls)
                apgu_pkg::CLS_RAM:
                    block = (ram_off < {10'h000, ram_lim});
                apgu_pkg::CLS_PORT_CFG:  block = ctrl.port_guard;
                apgu_pkg::CLS_PORT_DATA: block = 1'b0;
                apgu_pkg::CLS_IRQ_CFG:   block = ctrl.irq_guard;
                apgu_pkg::CLS_CHIP_CTL:  block = ctrl.chip_guard;
                default:                 block = 1'b0;
            endcase
        end
    end

endmodule : apgu_wr_guard

// ===== verilog/apgu_top.sv
`timescale 1ns/100ps
`include "apgu_defs.svh"

module apgu_top (
    input  wire logic                 SYS_CLK,       // 125 MHz clock
    input  wire logic                 RESET,         // Sync reset, high
    input  wire logic                 WDT_OPT_EN,    // Watchdog option on
    input  wire apgu_pkg::apgu_wr_t   CPU_WR,        // CPU write beat in
    input  wire logic                 CPU_INVALID,   // Access is invalid
    output logic                      TGT_WR_VALID,  // Filtered strobe
    output logic [19:0]               TGT_WR_ADDR,   // Filtered address
    output logic [7:0]                TGT_WR_DATA,   // Filtered data
    output logic                      INT_RESET_REQ, // Internal reset
    output logic                      IRQ,           // Level interrupt
    input  wire logic [19:0]          S_AXI_AWADDR,  // Write address
    input  wire logic                 S_AXI_AWVALID, // Write addr valid
    output logic                      S_AXI_AWREADY, // Write addr ready
    input  wire logic [31:0]          S_AXI_WDATA,   // Write data
    input  wire logic [3:0]           S_AXI_WSTRB,   // Write strobes
    input  wire logic                 S_AXI_WVALID,  // Write data valid
    output logic                      S_AXI_WREADY,  // Write data ready
    output logic [1:0]                S_AXI_BRESP,   // Write response
    output logic                      S_AXI_BVALID,  // Response valid
    input  wire logic                 S_AXI_BREADY,  // Response ready
    input  wire logic [19:0]          S_AXI_ARADDR,  // Read address
    input  wire logic                 S_AXI_ARVALID, // Read addr valid
    output logic                      S_AXI_ARREADY, // Read addr ready
    output logic [31:0]               S_AXI_RDATA,   // Read data
    output logic [1:0]                S_AXI_RRESP,   // Read response
    output logic                      S_AXI_RVALID,  // Read data valid
    input  wire logic                 S_AXI_RREADY   // Read data ready
);

    // Protection and event state
    apgu_pkg::apgu_ctrl_t       ctrl_r;      // Protection control
    apgu_pkg::apgu_ctrl_t       ctrl_nxt;
    logic                       flag_r;      // Violation reset flag
    logic                       flag_nxt;
    logic [`APGU_EVT_W-1:0]     sts_r;       // Sticky event status
    logic [`APGU_EVT_W-1:0]     sts_nxt;
    logic [`APGU_EVT_W-1:0]     mask_r;      // Event mask
    logic [`APGU_EVT_W-1:0]     mask_nxt;
    logic                       irq_r;       // Registered interrupt
    logic                       irq_nxt;

    // CPU write path
    logic                       tvalid_r;    // Filtered strobe
    logic                       tvalid_nxt;
    logic [19:0]                taddr_r;     // Filtered address
    logic [19:0]                taddr_nxt;
    logic [7:0]                 tdata_r;     // Filtered data
    logic [7:0]                 tdata_nxt;
    logic                       rstreq_r;    // Internal reset pulse
    logic                       rstreq_nxt;
    logic                       blocked;     // Guard drops this write
    logic                       det_on;      // Effective detection
    logic                       viol_hit;    // Violation that resets
    logic                       viol_quiet;  // Violation, detection off

    // Write channel state
    logic                       aw_got_r;    // Address captured
    logic                       aw_got_nxt;
    logic                       w_got_r;     // Data captured
    logic                       w_got_nxt;
    logic [19:0]                awaddr_r;    // Captured address
    logic [19:0]                awaddr_nxt;
    logic [7:0]                 wdata_r;     // Captured low byte
    logic [7:0]                 wdata_nxt;
    logic                       wstrb_r;     // Captured lane 0 strobe
    logic                       wstrb_nxt;
    logic                       awready_r;
    logic                       awready_nxt;
    logic                       wready_r;
    logic                       wready_nxt;
    logic                       bvalid_r;
    logic                       bvalid_nxt;
    logic [1:0]                 bresp_r;
    logic [1:0]                 bresp_nxt;
    logic                       wr_fire;     // Apply captured write
    logic                       wr_hit;      // Address is mapped

    // Read channel state
    apgu_pkg::apgu_rd_st_t      rd_st_r;
    apgu_pkg::apgu_rd_st_t      rd_st_nxt;
    logic                       arready_r;
    logic                       arready_nxt;
    logic [31:0]                rdata_r;
    logic [31:0]                rdata_nxt;
    logic [1:0]                 rresp_r;
    logic [1:0]                 rresp_nxt;
    logic                       rd_take;     // Read address taken

    // Guard decision for the current CPU write
    apgu_wr_guard u_guard (
        .ctrl  (ctrl_r),
        .wr    (CPU_WR),
        .block (blocked)
    );

    // Option strap forces detection on
    assign det_on     = ctrl_r.det_en | WDT_OPT_EN;
    assign viol_hit   = CPU_INVALID & det_on;
    assign viol_quiet = CPU_INVALID & ~det_on;

    // CPU write path: guard-dropped writes just vanish, no error raised
    always_comb begin
        tvalid_nxt = CPU_WR.valid & ~blocked & ~viol_hit;
        taddr_nxt  = CPU_WR.addr;
        tdata_nxt  = CPU_WR.data;
        rstreq_nxt = viol_hit;
    end

    // CPU write path registers
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            tvalid_r <= 1'b0;
            taddr_r  <= 20'h00000;
            tdata_r  <= 8'h00;
            rstreq_r <= 1'b0;
        end else begin
            tvalid_r <= tvalid_nxt;
            taddr_r  <= taddr_nxt;
            tdata_r  <= tdata_nxt;
            rstreq_r <= rstreq_nxt;
        end
    end

    // Write channel: address and data taken in either order
    assign wr_fire = aw_got_r & w_got_r & ~bvalid_r;
    assign wr_hit  = (awaddr_r == `APGU_CTRL_ADDR)  ||
                     (awaddr_r == `APGU_CAUSE_ADDR) ||
                     (awaddr_r == `APGU_STS_ADDR)   ||
                     (awaddr_r == `APGU_MASK_ADDR);

    always_comb begin
        aw_got_nxt = aw_got_r;
        w_got_nxt  = w_got_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt  = wdata_r;
        wstrb_nxt  = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt  = bresp_r;
        // Capture address
        if (S_AXI_AWVALID && awready_r) begin
            aw_got_nxt = 1'b1;
            awaddr_nxt = S_AXI_AWADDR;
        end
        // Capture data, only lane 0 carries register bits
        if (S_AXI_WVALID && wready_r) begin
            w_got_nxt = 1'b1;
            wdata_nxt = S_AXI_WDATA[7:0];
            wstrb_nxt = S_AXI_WSTRB[0];
        end
        // Both present: answer
        if (wr_fire) begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = wr_hit ? `APGU_RESP_OKAY : `APGU_RESP_SLVERR;
        end
        // Response consumed
        if (bvalid_r && S_AXI_BREADY) begin
            bvalid_nxt = 1'b0;
        end
        // Ready only while the slot is free; one write in flight
        awready_nxt = ~aw_got_nxt & ~bvalid_nxt;
        wready_nxt  = ~w_got_nxt & ~bvalid_nxt;
    end

    // Write channel registers
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            awaddr_r  <= 20'h00000;
            wdata_r   <= 8'h00;
            wstrb_r   <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `APGU_RESP_OKAY;
        end else begin
            aw_got_r  <= aw_got_nxt;
            w_got_r   <= w_got_nxt;
            awaddr_r  <= awaddr_nxt;
            wdata_r   <= wdata_nxt;
            wstrb_r   <= wstrb_nxt;
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
        end
    end

    // Read channel: data is latched in the same edge as the address
    assign rd_take = (rd_st_r == apgu_pkg::RD_IDLE) & arready_r &
                     S_AXI_ARVALID;

    always_comb begin
        rd_st_nxt   = rd_st_r;
        arready_nxt = arready_r;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        case (rd_st_r)
            apgu_pkg::RD_IDLE: begin
                arready_nxt = 1'b1;
                if (rd_take) begin
                    rd_st_nxt   = apgu_pkg::RD_RESP;
                    arready_nxt = 1'b0;
                    rresp_nxt   = `APGU_RESP_OKAY;
                    case (S_AXI_ARADDR)
                        `APGU_CTRL_ADDR: begin
                            // Reserved bits 6 and 3 held at zero
                            rdata_nxt = {24'h000000, ctrl_r};
                        end
                        `APGU_CAUSE_ADDR: begin
                            rdata_nxt = {31'h00000000, flag_r};
                        end
                        `APGU_STS_ADDR: begin
                            rdata_nxt = {30'h00000000, sts_r};
                        end
                        `APGU_MASK_ADDR: begin
                            rdata_nxt = {30'h00000000, mask_r};
                        end
                        default: begin
                            rdata_nxt = 32'h00000000;
                            rresp_nxt = `APGU_RESP_SLVERR;
                        end
                    endcase
                end
            end
            apgu_pkg::RD_RESP: begin
                if (S_AXI_RREADY) begin
                    rd_st_nxt   = apgu_pkg::RD_IDLE;
                    arready_nxt = 1'b1;
                end
            end
            default: begin
                rd_st_nxt   = apgu_pkg::RD_IDLE;
                arready_nxt = 1'b0;
            end
        endcase
    end

    // Read channel registers
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            rd_st_r   <= apgu_pkg::RD_IDLE;
            arready_r <= 1'b0;
            rdata_r   <= 32'h00000000;
            rresp_r   <= `APGU_RESP_OKAY;
        end else begin
            rd_st_r   <= rd_st_nxt;
            arready_r <= arready_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
        end
    end

    // Register file: software effects first, hardware events last
    always_comb begin
        ctrl_nxt = ctrl_r;
        flag_nxt = flag_r;
        sts_nxt  = sts_r;
        mask_nxt = mask_r;
        if (wr_fire && wstrb_r) begin
            case (awaddr_r)
                `APGU_CTRL_ADDR: begin
                    // Guard bits do not protect this register itself
                    ctrl_nxt = apgu_pkg::apgu_ctrl_t'(
                        wdata_r & `APGU_CTRL_WMASK);
                    // Enable cannot be cleared by software
                    ctrl_nxt.det_en = ctrl_r.det_en |
                        wdata_r[`APGU_DET_EN_BIT];
                end
                `APGU_STS_ADDR: begin
                    sts_nxt = sts_r & ~wdata_r[`APGU_EVT_W-1:0];
                end
                `APGU_MASK_ADDR: begin
                    mask_nxt = wdata_r[`APGU_EVT_W-1:0];
                end
                default: begin
                    ctrl_nxt = ctrl_r;
                end
            endcase
        end
        // Cause flag clears when software reads it
        if (rd_take && (S_AXI_ARADDR == `APGU_CAUSE_ADDR)) begin
            flag_nxt = 1'b0;
        end
        // Violation acts as a reset of the control register
        if (viol_hit) begin
            ctrl_nxt = apgu_pkg::apgu_ctrl_t'(`APGU_CTRL_RST);
            flag_nxt = 1'b1;
            sts_nxt[`APGU_EVT_VIOL_RST] = 1'b1;
        end
        // Invalid access seen with detection off, no reset
        if (viol_quiet) begin
            sts_nxt[`APGU_EVT_VIOL_QUIET] = 1'b1;
        end
        irq_nxt = |(sts_nxt & mask_nxt);
    end

    // Register file registers
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            ctrl_r <= apgu_pkg::apgu_ctrl_t'(`APGU_CTRL_RST);
            flag_r <= 1'b0;
            sts_r  <= `APGU_EVT_RST;
            mask_r <= `APGU_EVT_RST;
            irq_r  <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            flag_r <= flag_nxt;
            sts_r  <= sts_nxt;
            mask_r <= mask_nxt;
            irq_r  <= irq_nxt;
        end
    end

    // Outputs straight from flip-flops, RVALID decoded from the read state
    assign TGT_WR_VALID  = tvalid_r;
    assign TGT_WR_ADDR   = taddr_r;
    assign TGT_WR_DATA   = tdata_r;
    assign INT_RESET_REQ = rstreq_r;
    assign IRQ           = irq_r;
    assign S_AXI_AWREADY = awready_r;
    assign S_AXI_WREADY  = wready_r;
    assign S_AXI_BVALID  = bvalid_r;
    assign S_AXI_BRESP   = bresp_r;
    assign S_AXI_ARREADY = arready_r;
    assign S_AXI_RVALID  = (rd_st_r == apgu_pkg::RD_RESP);
    assign S_AXI_RDATA   = rdata_r;
    assign S_AXI_RRESP   = rresp_r;

endmodule : apgu_top

// ===== testbench/apgu_properties.sv
`timescale 1ns/100ps
`include "apgu_defs.svh"

module apgu_properties (
    input wire logic               SYS_CLK,       // Clock
    input wire logic               RESET,         // Sync reset
    input wire logic               WDT_OPT_EN,    // Watchdog strap
    input wire apgu_pkg::apgu_wr_t CPU_WR,        // Cpu write beat
    input wire logic               CPU_INVALID,   // Invalid mark
    input wire logic               TGT_WR_VALID,  // Filtered strobe
    input wire logic [19:0]        TGT_WR_ADDR,   // Filtered address
    input wire logic [7:0]         TGT_WR_DATA,   // Filtered data
    input wire logic               INT_RESET_REQ, // Reset request
    input wire logic [19:0]        S_AXI_AWADDR,  // Write address
    input wire logic               S_AXI_AWVALID, // Addr valid
    input wire logic               S_AXI_AWREADY, // Addr ready
    input wire logic               S_AXI_WVALID,  // Data valid
    input wire logic               S_AXI_WREADY,  // Data ready
    input wire logic [1:0]         S_AXI_BRESP,   // Write response
    input wire logic               S_AXI_BVALID,  // Response valid
    input wire logic               S_AXI_ARVALID, // Read addr valid
    input wire logic               S_AXI_ARREADY, // Read addr ready
    input wire logic [31:0]        S_AXI_RDATA,   // Read data
    input wire logic               S_AXI_RVALID   // Read valid
);
    // Single domain, so one clock and one disable for all
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);

    AST_WDT_FORCES_RESET: assert property (CPU_INVALID && WDT_OPT_EN
        |=> INT_RESET_REQ) else $error("no reset request on invalid access");
    AST_RESET_HAS_CAUSE: assert property (INT_RESET_REQ
        |-> $past(CPU_INVALID)) else $error("reset request without cause");
    AST_INVALID_DROPPED: assert property (CPU_WR.valid && CPU_INVALID
        && WDT_OPT_EN |=> !TGT_WR_VALID) else $error("invalid write passed");
    AST_FREE_CLASS_PASS: assert property (CPU_WR.valid && !CPU_INVALID
        && CPU_WR.cls inside {apgu_pkg::CLS_PORT_DATA, apgu_pkg::CLS_OTHER}
        |=> TGT_WR_VALID) else $error("unguarded write dropped");
    AST_NO_SPURIOUS_WR: assert property (TGT_WR_VALID
        |-> $past(CPU_WR.valid)) else $error("write strobe without request");
    AST_WR_PAYLOAD: assert property (CPU_WR.valid
        |=> TGT_WR_ADDR == $past(CPU_WR.addr)
        && TGT_WR_DATA == $past(CPU_WR.data)) else $error("payload lost");
    AST_CTRL_WR_OKAY: assert property (S_AXI_AWVALID && S_AXI_AWREADY
        && S_AXI_WVALID && S_AXI_WREADY && S_AXI_AWADDR == `APGU_CTRL_ADDR
        |=> ##1 S_AXI_BVALID && S_AXI_BRESP == `APGU_RESP_OKAY)
        else $error("control write not answered okay");
    AST_READ_BYTE_LANE: assert property (S_AXI_ARVALID && S_AXI_ARREADY
        |=> S_AXI_RVALID && S_AXI_RDATA[31:8] == 24'h000000)
        else $error("read answer late or upper bits set");

    // Main scenarios reached
    COV_RESET_REQ: cover property (INT_RESET_REQ);
    COV_DROP: cover property (CPU_WR.valid ##1 !TGT_WR_VALID);
    COV_READ: cover property (S_AXI_ARVALID && S_AXI_ARREADY);
endmodule : apgu_properties

bind apgu_top apgu_properties u_props (.SYS_CLK, .RESET, .WDT_OPT_EN,
    .CPU_WR, .CPU_INVALID, .TGT_WR_VALID, .TGT_WR_ADDR, .TGT_WR_DATA,
    .INT_RESET_REQ, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID);

// ===== testbench/apgu_cpu_model.sv
`timescale 1ns/100ps

module apgu_cpu_model (
    input  wire logic          clk,        // System clock
    output apgu_pkg::apgu_wr_t CPU_WR,     // Write beat to guard
    output logic               CPU_INVALID // Invalid access mark
);
    // Idle from time zero
    initial begin
        CPU_WR = '{1'b0, 20'h00000, 8'h00, apgu_pkg::CLS_OTHER};
        CPU_INVALID = 1'b0;
    end

    // One write beat, payload inverted after
    task issue(input logic [19:0] a, input logic [7:0] d,
               input apgu_pkg::apgu_cls_t c, input logic inv);
        @(posedge clk);
        CPU_WR <= '{1'b1, a, d, c};
        CPU_INVALID <= inv;
        @(posedge clk);
        CPU_WR <= '{1'b0, ~a, ~d, c};
        CPU_INVALID <= 1'b0;
    endtask : issue
endmodule : apgu_cpu_model

// ===== testbench/apgu_tb.sv
`timescale 1ns/100ps
`include "apgu_defs.svh"

module apgu_tb;
    logic               SYS_CLK = 1'b0;    // 125 MHz clock
    logic               RESET = 1'b1;      // Sync reset
    logic               WDT_OPT_EN = 1'b0; // Watchdog strap
    apgu_pkg::apgu_wr_t CPU_WR;            // From cpu model
    logic               CPU_INVALID;       // From cpu model
    logic               TGT_WR_VALID;      // Filtered strobe
    logic               INT_RESET_REQ;     // Reset request
    logic               IRQ;               // Interrupt level
    logic [19:0]        TGT_WR_ADDR;       // Filtered address
    logic [7:0]         TGT_WR_DATA;       // Filtered data
    logic [19:0]        S_AXI_AWADDR = 20'h00000;
    logic [19:0]        S_AXI_ARADDR = 20'h00000;
    logic [31:0]        S_AXI_WDATA = 32'h00000000;
    logic [31:0]        S_AXI_RDATA;
    logic [3:0]         S_AXI_WSTRB = 4'h0;
    logic               S_AXI_AWVALID = 1'b0;
    logic               S_AXI_WVALID = 1'b0;
    logic               S_AXI_BREADY = 1'b1;
    logic               S_AXI_ARVALID = 1'b0;
    logic               S_AXI_RREADY = 1'b1;
    logic               S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
    logic               S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0]         S_AXI_BRESP, S_AXI_RRESP;
    logic [7:0]         gbit [3] = '{8'h04, 8'h02, 8'h01}; // Guard bits
    apgu_pkg::apgu_cls_t gcls [3] = '{apgu_pkg::CLS_PORT_CFG,
        apgu_pkg::CLS_IRQ_CFG, apgu_pkg::CLS_CHIP_CTL}; // Guarded kinds
    int                 errors = 0;        // Mismatch count
    int                 tests_run = 0;     // Compare count
    localparam logic [19:0] ctl_a = `APGU_CTRL_ADDR; // Control reg

    apgu_top dut (.SYS_CLK, .RESET, .WDT_OPT_EN, .CPU_WR, .CPU_INVALID,
        .TGT_WR_VALID, .TGT_WR_ADDR, .TGT_WR_DATA, .INT_RESET_REQ, .IRQ,
        .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
        .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
        .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
        .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
        .S_AXI_RREADY);
    apgu_cpu_model cpu (.clk(SYS_CLK), .CPU_WR, .CPU_INVALID);

    // Clock, 8 ns period
    initial begin
        forever #4 SYS_CLK = ~SYS_CLK;
    end

    // Verdict and end of run
    task results;
        $display("compares %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // Compare; case inequality so unknowns fail
    task check(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Bus write, each channel released once taken
    task wr(input logic [19:0] a, input logic [7:0] d,
            input logic [1:0] er = `APGU_RESP_OKAY);
        logic done;
        done = 1'b0;
        S_AXI_AWADDR <= a;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WDATA <= {24'h000000, d};
        S_AXI_WSTRB <= 4'hf;
        S_AXI_WVALID <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge SYS_CLK);
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                S_AXI_AWVALID <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                S_AXI_WVALID <= 1'b0;
            end
            if (S_AXI_BVALID) begin
                check("bresp", S_AXI_BRESP, er);
                done = 1'b1;
            end
        end
        check("write_done", done, 1'b1);
        if (!done) results();
    endtask : wr

    // Bus read with data and response compare
    task rd(input logic [19:0] a, input logic [31:0] e,
            input logic [1:0] er = `APGU_RESP_OKAY);
        logic done;
        done = 1'b0;
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge SYS_CLK);
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_ARVALID <= 1'b0;
            end
            if (S_AXI_RVALID) begin
                check("rdata", S_AXI_RDATA, e);
                check("rresp", S_AXI_RRESP, er);
                done = 1'b1;
            end
        end
        check("read_done", done, 1'b1);
        if (!done) results();
    endtask : rd

    // Cpu write beat, filtered strobe one cycle on
    task cw(input logic [19:0] a, input apgu_pkg::apgu_cls_t c,
            input logic inv, input logic ev);
        cpu.issue(a, a[7:0] ^ 8'h5a, c, inv);
        #1;
        check("tgt_valid", TGT_WR_VALID, ev);
        check("tgt_addr", TGT_WR_ADDR, a);
    endtask : cw

    // Hang guard
    initial begin
        repeat (20000) @(posedge SYS_CLK);
        check("run_done", 0, 1);
        results();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge SYS_CLK);
        RESET <= 1'b0;
        rd(ctl_a, 32'h00);
        rd(`APGU_CAUSE_ADDR, 32'h00);
        wr(20'hf0090, 8'h01, `APGU_RESP_SLVERR);
        rd(20'hf0090, 32'h00, `APGU_RESP_SLVERR);
        wr(ctl_a, 8'h7f);
        rd(ctl_a, 32'h37);
        wr(ctl_a, 8'h07);
        rd(ctl_a, 32'h07);
        cw(20'h00104, apgu_pkg::CLS_PORT_DATA, 1'b0, 1'b1);
        $display("test registers done");
        // Each guard drops only while its bit is set
        for (int k = 0; k < 3; k++) begin
            wr(ctl_a, gbit[k]);
            cw(20'h00100, gcls[k], 1'b0, 1'b0);
            wr(ctl_a, 8'h00);
            cw(20'h00100, gcls[k], 1'b0, 1'b1);
        end
        $display("test guards done");
        // Edges of every ram guard size
        for (int k = 0; k < 4; k++) begin
            int sz;
            sz = (k == 0) ? 0 : (64 << k);
            wr(ctl_a, {2'h0, k[1:0], 4'h0});
            cw(20'(`APGU_RAM_BASE + sz - 1), apgu_pkg::CLS_RAM, 1'b0,
               k == 0);
            cw(20'(`APGU_RAM_BASE + sz), apgu_pkg::CLS_RAM, 1'b0, 1'b1);
        end
        $display("test ram guard done");
        // Detection off: event only, no reset
        wr(ctl_a, 8'h00);
        cw(20'h00200, apgu_pkg::CLS_OTHER, 1'b1, 1'b1);
        check("int_reset", INT_RESET_REQ, 1'b0);
        rd(`APGU_STS_ADDR, 32'h02);
        check("irq_masked", IRQ, 1'b0);
        wr(`APGU_MASK_ADDR, 8'h02);
        @(posedge SYS_CLK);
        #1;
        check("irq_raised", IRQ, 1'b1);
        wr(`APGU_STS_ADDR, 8'h02);
        @(posedge SYS_CLK);
        #1;
        check("irq_cleared", IRQ, 1'b0);
        $display("test detection off done");
        // Detection on, sticky, then a violation
        wr(ctl_a, 8'h80);
        wr(ctl_a, 8'h00);
        rd(ctl_a, 32'h80);
        cw(20'h00200, apgu_pkg::CLS_OTHER, 1'b1, 1'b0);
        check("int_reset", INT_RESET_REQ, 1'b1);
        rd(ctl_a, 32'h00);
        rd(`APGU_CAUSE_ADDR, 32'h01);
        rd(`APGU_CAUSE_ADDR, 32'h00);
        rd(`APGU_STS_ADDR, 32'h01);
        $display("test detection on done");
        // Watchdog strap forces detection
        WDT_OPT_EN <= 1'b1;
        cw(20'h00200, apgu_pkg::CLS_OTHER, 1'b1, 1'b0);
        check("int_reset", INT_RESET_REQ, 1'b1);
        WDT_OPT_EN <= 1'b0;
        $display("test watchdog done");
        results();
    end
endmodule : apgu_tb
